// ===== hdl/rtc_pkg.sv
/*
 * Constants, register map, field positions and carrier types shared by the
 * refresh timer control block and its prescaler.
 * Assumes a single 10 MHz system clock and a byte-wide register port.
 */
// Notes on behaviour
// - refresh cycles for area 3 only when enabled
// - refresh pin driven only when pin enabled
// - column width and strobe arrangement selection
// - memory type bits pick timer, DRAM, PSRAM
// - self-refresh in standby only when enabled
// - match flag set when counter equals constant
// - flag cleared by read-one then write-zero
package rtc_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CONTROL = 8'hAC;
	localparam logic [7:0] OFS_TIMER_CS = 8'hAD;
	localparam logic [7:0] OFS_COUNTER = 8'hAE;
	localparam logic [7:0] OFS_CONSTANT = 8'hAF;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'hB8;
	localparam logic [7:0] OFS_IRQ_MASK = 8'hB9;
	localparam logic [7:0] RST_CONTROL = 8'h02;
	localparam logic [7:0] RST_TIMER_CS = 8'h07;
	localparam logic [7:0] RST_COUNTER = 8'h00;
	localparam logic [7:0] RST_CONSTANT = 8'hFF;
	localparam logic [7:0] RST_IRQ = 8'h00;
	localparam logic [2:0] TCS_RSVD_ONES = 3'h7;
	// control register field positions
	localparam int B_SELF_REFRESH = 7;
	localparam int B_PSRAM = 6;
	localparam int B_DRAM = 5;
	localparam int B_STROBE_CAS = 4;
	localparam int B_COLUMN9 = 3;
	localparam int B_PIN_EN = 1;
	localparam int B_CYCLE_EN = 0;
	// timer control/status field positions
	localparam int B_MATCH_FLAG = 7;
	localparam int B_MATCH_IRQ_EN = 6;
	localparam int B_CKS_HI = 5;
	localparam int B_CKS_LO = 3;
	// prescaler taps, as log2 of the divide ratio for codes 1..7
	localparam int PRESC_W = 12;
	localparam int TAP_LOG2 [1:7] = '{1, 3, 5, 7, 9, 11, 12};
	// refresh strobe pulse width on the pin, in ns and cycles
	localparam int CLK_PERIOD_NS = 100;
	localparam int REFRESH_PULSE_NS = 200;
	localparam int REFRESH_PULSE_CYC =
		(REFRESH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		RTC_MEM_TIMER,
		RTC_MEM_DRAM,
		RTC_MEM_PSRAM,
		RTC_MEM_ILLEGAL
	} rtc_mem_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rtc_bus_t;

	typedef struct packed {
		logic refresh_req;
		logic column9;
		logic strobe_cas;
		logic dram_sel;
		logic psram_sel;
		logic self_refresh;
	} rtc_mem_ctl_t;
endpackage : rtc_pkg

// ===== hdl/rtc_prescaler.sv
/*
 * Free-running prescaler giving a one-cycle enable at the selected tap.
 * Assumes the reset is already synchronised by the top module.
 */
`timescale 1ns/1ps
module rtc_prescaler #(
	parameter int W = rtc_pkg::PRESC_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [2:0] sel_i,
	output logic tick_o
);
	import rtc_pkg::*;
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	// the counter runs freely; a tap is a carry out of its low bits
	always_comb begin
		next_count = count + 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// tick when the low tap bits wrap to zero; code 0 never ticks
	always_comb begin
		tick_o = 1'b0;
		if (sel_i != 3'h0) begin
			for (int k = 1; k <= 7; k++) begin
				if (sel_i == 3'(k)) begin
					tick_o = ((next_count &
						W'((1 << TAP_LOG2[k]) - 1)) == '0);
				end
			end
		end
	end
endmodule : rtc_prescaler

// ===== hdl/rtc_refresh_timer.sv
/*
 * Refresh timer control block: control and status registers, refresh
 * timer counter with compare match, interrupt and memory control outputs.
 * Assumes register strobes are synchronous one-cycle pulses and that the
 * memory controller proper consumes the control bundle.
 */
`timescale 1ns/1ps
module rtc_refresh_timer (
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic [rtc_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic STANDBY_I,
	output logic [7:0] RDATA_O,
	output logic IRQ_O,
	output logic REFRESH_N_O,
	output logic REFRESH_REQ_O,
	output logic COLUMN9_O,
	output logic STROBE_CAS_O,
	output logic DRAM_SEL_O,
	output logic PSRAM_SEL_O,
	output logic SELF_REFRESH_O
);
	import rtc_pkg::*;

	logic rst_meta;
	logic rst_n;
	rtc_bus_t bus;
	logic [7:0] control;
	logic [7:0] next_control;
	logic compare_match_flag;
	logic next_compare_match_flag;
	logic compare_match_irq_enable;
	logic next_compare_match_irq_enable;
	logic [2:0] cks;
	logic [2:0] next_cks;
	logic [7:0] counter;
	logic [7:0] next_counter;
	logic [7:0] constant;
	logic [7:0] next_constant;
	logic [1:0] irq_status;
	logic [1:0] next_irq_status;
	logic [1:0] irq_mask;
	logic [1:0] next_irq_mask;
	logic flag_read_armed;
	logic next_flag_read_armed;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic [1:0] pulse_cnt;
	logic [1:0] next_pulse_cnt;
	logic tick;
	logic match;
	logic refresh_fire;
	rtc_mem_t mem_type;
	rtc_mem_ctl_t mem_ctl;
	rtc_mem_t next_mem_type;
	rtc_mem_ctl_t mode_q;
	rtc_mem_ctl_t next_mode;
	logic refresh_n;
	logic next_refresh_n;

	// reset release through two flops; assertion is still immediate
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	rtc_prescaler #(
		.W(PRESC_W)
	) u_presc (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n),
		.sel_i(cks),
		.tick_o(tick)
	);

	// match is evaluated on the counter's own clock enable so a stopped
	// counter sitting on the constant does not refire every cycle
	assign match = tick && (counter == constant);
	assign mem_type = rtc_mem_t'({control[B_PSRAM], control[B_DRAM]});
	// refresh only on area 3 with DRAM or PSRAM attached
	assign refresh_fire = match && control[B_CYCLE_EN] &&
		(mem_type == RTC_MEM_DRAM || mem_type == RTC_MEM_PSRAM);

	// register writes, flag handling and counting
	always_comb begin
		next_control = control;
		next_compare_match_irq_enable = compare_match_irq_enable;
		next_cks = cks;
		next_constant = constant;
		next_counter = counter;
		next_compare_match_flag = compare_match_flag;
		next_flag_read_armed = flag_read_armed;
		// counting; restart from zero on match
		if (tick) begin
			next_counter = match ? 8'h00 : counter + 8'h01;
		end
		// read of the flag as one arms the clear
		if (bus.rd && bus.addr == OFS_TIMER_CS &&
			compare_match_flag) begin
			next_flag_read_armed = 1'b1;
		end
		if (bus.wr) begin
			case (bus.addr)
				OFS_CONTROL: begin
					// 11 is illegal; software must avoid it, stored as is
					next_control = bus.wdata;
				end
				OFS_TIMER_CS: begin
					next_compare_match_irq_enable =
						bus.wdata[B_MATCH_IRQ_EN];
					next_cks = bus.wdata[B_CKS_HI:B_CKS_LO];
					// writing one is ignored; zero clears only if read first
					if (!bus.wdata[B_MATCH_FLAG] && flag_read_armed) begin
						next_compare_match_flag = 1'b0;
					end
					// any write here spends the arming, cleared or not
					next_flag_read_armed = 1'b0;
				end
				OFS_COUNTER: begin
					next_counter = bus.wdata;
				end
				OFS_CONSTANT: begin
					next_constant = bus.wdata;
				end
				default: begin
				end
			endcase
		end
		// hardware set wins over a simultaneous clear
		if (match) begin
			next_compare_match_flag = 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			control <= RST_CONTROL;
			compare_match_flag <= RST_TIMER_CS[B_MATCH_FLAG];
			compare_match_irq_enable <= RST_TIMER_CS[B_MATCH_IRQ_EN];
			cks <= RST_TIMER_CS[B_CKS_HI:B_CKS_LO];
			counter <= RST_COUNTER;
			constant <= RST_CONSTANT;
			flag_read_armed <= 1'b0;
		end else begin
			control <= next_control;
			compare_match_flag <= next_compare_match_flag;
			compare_match_irq_enable <= next_compare_match_irq_enable;
			cks <= next_cks;
			counter <= next_counter;
			constant <= next_constant;
			flag_read_armed <= next_flag_read_armed;
		end
	end

	// sticky interrupt status, write one to clear; a set in the same
	// cycle as the clear wins so no event is ever lost
	always_comb begin
		next_irq_status = irq_status;
		next_irq_mask = irq_mask;
		if (bus.wr && bus.addr == OFS_IRQ_STATUS) begin
			next_irq_status = irq_status & ~bus.wdata[1:0];
		end
		if (bus.wr && bus.addr == OFS_IRQ_MASK) begin
			next_irq_mask = bus.wdata[1:0];
		end
		if (match) begin
			next_irq_status[0] = 1'b1;
		end
		if (refresh_fire) begin
			next_irq_status[1] = 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= RST_IRQ[1:0];
			irq_mask <= RST_IRQ[1:0];
		end else begin
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
		end
	end

	// read data, valid in the cycle after the read strobe only
	always_comb begin
		next_rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				OFS_CONTROL: next_rdata = control;
				OFS_TIMER_CS: next_rdata = {compare_match_flag,
					compare_match_irq_enable, cks, TCS_RSVD_ONES};
				OFS_COUNTER: next_rdata = counter;
				OFS_CONSTANT: next_rdata = constant;
				OFS_IRQ_STATUS: next_rdata = {6'h00, irq_status};
				OFS_IRQ_MASK: next_rdata = {6'h00, irq_mask};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// refresh pin pulse stretcher; pulse held a fixed width on the pin
	always_comb begin
		next_pulse_cnt = pulse_cnt;
		if (refresh_fire) begin
			next_pulse_cnt = 2'(REFRESH_PULSE_CYC);
		end else if (pulse_cnt != 2'h0) begin
			next_pulse_cnt = pulse_cnt - 2'h1;
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			pulse_cnt <= 2'h0;
		end else begin
			pulse_cnt <= next_pulse_cnt;
		end
	end

	// mode pins and the refresh pin are registered from next values, so
	// they move on the same edge as the register and never glitch
	always_comb begin
		next_mem_type = rtc_mem_t'({next_control[B_PSRAM],
			next_control[B_DRAM]});
		next_mode = '0;
		next_mode.column9 = next_control[B_COLUMN9];
		next_mode.strobe_cas = next_control[B_STROBE_CAS];
		next_mode.dram_sel = (next_mem_type == RTC_MEM_DRAM);
		next_mode.psram_sel = (next_mem_type == RTC_MEM_PSRAM);
		// the pin follows the stretcher, gated by its enable bit
		next_refresh_n = !(next_control[B_PIN_EN] &&
			next_pulse_cnt != 2'h0);
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			// the reset control value attaches no memory
			mode_q <= '0;
			refresh_n <= 1'b1;
		end else begin
			mode_q <= next_mode;
			refresh_n <= next_refresh_n;
		end
	end

	// memory control bundle; request and self-refresh stay combinational
	always_comb begin
		mem_ctl = mode_q;
		mem_ctl.refresh_req = refresh_fire;
		// self-refresh only while standby and enabled, with memory fitted
		mem_ctl.self_refresh = STANDBY_I && control[B_SELF_REFRESH] &&
			(mode_q.dram_sel || mode_q.psram_sel);
	end

	assign RDATA_O = rdata;
	// level interrupt: legacy enable path or the masked sticky bits
	assign IRQ_O = (compare_match_flag && compare_match_irq_enable) ||
		|(irq_status & irq_mask);
	assign REFRESH_N_O = refresh_n;
	assign REFRESH_REQ_O = mem_ctl.refresh_req;
	assign COLUMN9_O = mem_ctl.column9;
	assign STROBE_CAS_O = mem_ctl.strobe_cas;
	assign DRAM_SEL_O = mem_ctl.dram_sel;
	assign PSRAM_SEL_O = mem_ctl.psram_sel;
	assign SELF_REFRESH_O = mem_ctl.self_refresh;
endmodule : rtc_refresh_timer

// ===== dv/rtc_mem_model.sv
/* Far-side memory model: takes every refresh request, counts pin strobes.
   Assumes an active-low refresh pin that idles high. */
`timescale 1ns/1ps
module rtc_mem_model (
	input wire logic clk_i,
	input wire logic refresh_n_i,
	input wire logic refresh_req_i,
	output int req_count_o,
	output int pin_count_o
);
	int n_req = 0;
	int n_pin = 0;
	logic pin_prev = 1'b1;
	assign req_count_o = n_req;
	assign pin_count_o = n_pin;
	// mid-cycle sampling, since the request is a combinational pulse
	always @(negedge clk_i) begin
		pin_prev <= refresh_n_i;
		if (refresh_req_i === 1'b1) n_req <= n_req + 1;
		if (pin_prev === 1'b1 && refresh_n_i === 1'b0) n_pin <= n_pin + 1;
	end
endmodule : rtc_mem_model

// ===== dv/rtc_refresh_timer_properties.sv
/* Port checker for the refresh timer control block.
   Sees only the top-level ports; bound after the module. */
`timescale 1ns/1ps
module rtc_timer_checker
	import rtc_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic [rtc_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic STANDBY_I,
	input wire logic [7:0] RDATA_O,
	input wire logic REFRESH_N_O,
	input wire logic REFRESH_REQ_O,
	input wire logic COLUMN9_O,
	input wire logic STROBE_CAS_O,
	input wire logic DRAM_SEL_O,
	input wire logic PSRAM_SEL_O,
	input wire logic SELF_REFRESH_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	// outputs tied to their causes; the pin may never strobe on its own
	req_mem_a: assert property (
		REFRESH_REQ_O |-> DRAM_SEL_O || PSRAM_SEL_O) else $error("bad req");
	pin_source_a: assert property (
		$fell(REFRESH_N_O) |-> $past(REFRESH_REQ_O)) else $error("bad pin");
	pin_width_a: assert property (
		$fell(REFRESH_N_O) |=> !REFRESH_N_O) else $error("short pin");
	col_strobe_a: assert property (
		WR_I && ADDR_I == OFS_CONTROL |=>
		{STROBE_CAS_O, COLUMN9_O} == $past(WDATA_I[4:3])) else $error("col");
	type_decode_a: assert property (
		WR_I && ADDR_I == OFS_CONTROL |=>
		DRAM_SEL_O == ($past(WDATA_I[6:5]) == 2'b01) &&
		PSRAM_SEL_O == ($past(WDATA_I[6:5]) == 2'b10)) else $error("type");
	self_ref_a: assert property (
		SELF_REFRESH_O |-> STANDBY_I && (DRAM_SEL_O || PSRAM_SEL_O))
		else $error("self refresh");
	rsvd_ones_a: assert property (
		RD_I && ADDR_I == OFS_TIMER_CS |=> RDATA_O[2:0] == TCS_RSVD_ONES)
		else $error("reserved bits");
	req_pulse_a: assert property (
		REFRESH_REQ_O |=> !REFRESH_REQ_O) else $error("long req");
endmodule : rtc_timer_checker
bind rtc_refresh_timer rtc_timer_checker u_chk (.CLOCK_I(CLOCK_I),
	.RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
	.RD_I(RD_I), .STANDBY_I(STANDBY_I), .RDATA_O(RDATA_O),
	.REFRESH_N_O(REFRESH_N_O), .REFRESH_REQ_O(REFRESH_REQ_O),
	.COLUMN9_O(COLUMN9_O), .STROBE_CAS_O(STROBE_CAS_O),
	.DRAM_SEL_O(DRAM_SEL_O), .PSRAM_SEL_O(PSRAM_SEL_O),
	.SELF_REFRESH_O(SELF_REFRESH_O));

// ===== dv/tb.sv
/* Self-checking bench for the refresh timer control block.
   Assumes the memory model and the port checker are compiled first. */
`timescale 1ns/1ps
module tb;
	import rtc_pkg::*;
	logic clk = 0, rst_n = 0, we = 0, re = 0, stby = 0;
	logic [7:0] addr = 0, wdata = 0, rdata;
	logic irq, rfn, req, col9, cas, dsel, psel, sref;
	int n_errors = 0, check_count = 0, n_req, n_pin;
	rtc_refresh_timer u_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(we), .RD_I(re), .STANDBY_I(stby),
		.RDATA_O(rdata), .IRQ_O(irq), .REFRESH_N_O(rfn), .REFRESH_REQ_O(req),
		.COLUMN9_O(col9), .STROBE_CAS_O(cas), .DRAM_SEL_O(dsel),
		.PSRAM_SEL_O(psel), .SELF_REFRESH_O(sref));
	rtc_mem_model u_mem (.clk_i(clk), .refresh_n_i(rfn), .refresh_req_i(req),
		.req_count_o(n_req), .pin_count_o(n_pin));
	// 10 MHz clock
	initial forever #50 clk = ~clk;
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd
	// bounded so a dead timer cannot hang the run
	task automatic wait_req(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (req !== 1'b1 && n < 5000);
		if (req !== 1'b1) begin
			n_errors++;
			$display("FAIL %0t no refresh request in time", $time);
		end
	endtask : wait_req
	task automatic t_regs;
		rd(OFS_CONTROL, RST_CONTROL);
		rd(OFS_TIMER_CS, RST_TIMER_CS);
		rd(OFS_COUNTER, RST_COUNTER);
		rd(OFS_CONSTANT, RST_CONSTANT);
		rd(8'h00, 8'h00);
		wr(OFS_COUNTER, 8'h5A);
		rd(OFS_COUNTER, 8'h5A);
		$display("register test done");
	endtask : t_regs
	task automatic t_sweep;
		int n, p0, r0;
		int div [1:7] = '{2, 8, 32, 128, 512, 2048, 4096};
		wr(OFS_CONSTANT, 8'h00);
		wr(OFS_CONTROL, 8'h21);
		p0 = n_pin;
		for (int k = 1; k < 8; k++) begin
			wr(OFS_TIMER_CS, {2'b00, 3'(k), 3'b000});
			wait_req(n);
			wait_req(n);
			chk(8'(n == div[k]), 8'h01);
		end
		chk(8'(n_pin == p0), 8'h01);
		wr(OFS_CONTROL, 8'h20);
		wr(OFS_TIMER_CS, 8'h08);
		r0 = n_req;
		repeat (20) @(negedge clk);
		chk(8'(n_req == r0), 8'h01);
		wr(OFS_CONTROL, 8'h61);
		repeat (20) @(negedge clk);
		chk(8'(n_req == r0), 8'h01);
		wr(OFS_CONTROL, 8'h01);
		repeat (20) @(negedge clk);
		chk(8'(n_req == r0), 8'h01);
		wr(OFS_CONSTANT, 8'h03);
		wr(OFS_CONTROL, 8'h43);
		wait_req(n);
		wait_req(n);
		chk(8'(n), 8'h08);
		repeat (2) @(negedge clk);
		chk(8'(n_pin > p0), 8'h01);
		$display("timer sweep test done");
	endtask : t_sweep
	task automatic t_irq;
		int n;
		wr(OFS_IRQ_MASK, 8'h00);
		wr(OFS_TIMER_CS, 8'h08);
		wait_req(n);
		@(negedge clk);
		chk({7'h00, irq}, 8'h00);
		wr(OFS_TIMER_CS, 8'h40);
		#1 chk({7'h00, irq}, 8'h01);
		wr(OFS_TIMER_CS, 8'h40);
		rd(OFS_TIMER_CS, 8'hC7);
		wr(OFS_TIMER_CS, 8'hC0);
		rd(OFS_TIMER_CS, 8'hC7);
		wr(OFS_IRQ_MASK, 8'h01);
		wr(OFS_TIMER_CS, 8'h40);
		rd(OFS_TIMER_CS, 8'h47);
		chk({7'h00, irq}, 8'h01);
		rd(OFS_IRQ_MASK, 8'h01);
		rd(OFS_IRQ_STATUS, 8'h03);
		wr(OFS_IRQ_STATUS, 8'h03);
		#1 chk({7'h00, irq}, 8'h00);
		rd(OFS_IRQ_STATUS, 8'h00);
		$display("flag and interrupt test done");
	endtask : t_irq
	task automatic t_modes;
		logic [7:0] v;
		logic [7:0] tbl [6] = '{8'hA8, 8'hD0, 8'hE0, 8'h00, 8'h20, 8'h48};
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			stby <= 1'(s);
			foreach (tbl[i]) begin
				v = tbl[i];
				wr(OFS_CONTROL, v);
				#1 chk({3'h0, sref, psel, dsel, cas, col9}, {3'h0,
					1'(s) & v[7] & ^v[6:5], v[6:5] == 2'b10,
					v[6:5] == 2'b01, v[4], v[3]});
			end
		end
		$display("memory mode test done");
	endtask : t_modes
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude
	// the sweep alone needs up to about 14000 cycles
	initial begin
		#5000000;
		n_errors++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_sweep();
		t_irq();
		t_modes();
		conclude();
	end
endmodule : tb
